/* core/mode_word_ctrl.sv */
/*
  Primary mode word decoder and burst sequencer of the memory device.
  Assumes command pins are synchronous to clk, one command per clock, and a
  controller that keeps the mode-set timing and precharge preconditions.
*/
//
// Contract
// - only burst lengths four and eight are supported
// - length eight: full interleave, sequential wraps within each half
// - bit three of the mode word picks sequential or interleaved order
// - back-to-back reads or writes continue without any gap
// - length eight: only read-on-read or write-on-write may interrupt
// - no burst terminate command exists; its encoding is flagged and otherwise ignored
// - start position from column bits one-zero, or two-zero for eight
// - sequential order increments modulo four inside each half, the starting half first
// - interleaved order is start xor a counter from zero
// - write recovery code 1..7 gives 2..8 cycles, 0 gives 9
// - recovery plus precharge period sets auto-precharge write delay
// - bit thirteen exists on byte-wide parts only, written as zero
// - cas latency code decode, with code two reserved
// - bit eight set starts a dll reset
// - cas latency in bits four to six, order bit at three
// - write recovery field in bits nine to eleven
`timescale 1ns/1ps
`default_nettype none

module mode_word_ctrl
  import mode_word_pkg::*;
#(
  parameter bit BYTE_WIDE = 1'b1,
  parameter logic [3:0] PRECHARGE_CYCLES = 4'h4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] ba,
  input wire logic [13:0] addr,
  output logic mode_loaded,
  output logic burst_len8,
  output logic burst_order_select,
  output logic [3:0] cas_latency,
  output logic [3:0] write_recovery,
  output logic [4:0] autopre_delay,
  output logic powerdown_exit_speed,
  output logic test_select_bit,
  output logic dll_reset_pulse,
  output logic bl_code_reserved,
  output logic cl_code_reserved,
  output logic a13_error,
  output logic burst_active,
  output logic burst_is_write,
  output logic col_valid,
  output logic [2:0] col_index,
  output logic interrupt_error,
  output logic terminate_seen
);

  typedef struct packed {
    logic mode_loaded;
    logic bl8;
    logic interleave;
    logic [3:0] cl;
    logic [3:0] wr;
    logic [4:0] dal;
    logic pd_slow;
    logic tm;
    logic dll_rst;
    logic bl_rsvd;
    logic cl_rsvd;
    logic a13_err;
    burst_state_t state;
    logic is_write;
    logic [2:0] start;
    logic [2:0] beat;
    logic col_valid;
    logic [2:0] col;
    logic intr_err;
    logic term_seen;
  } st_t;

  st_t st_q;
  st_t st_d;
  cmd_t cmd;
  logic [2:0] ord_col;
  logic [2:0] last_beat;
  logic [2:0] cl_code;
  logic [2:0] wr_code;

  // ==========================================================================
  // command decode from the control pins
  function automatic cmd_t decode_cmd(input logic cs_n_i, input logic ras_n_i,
                                      input logic cas_n_i, input logic we_n_i,
                                      input logic [2:0] ba_i);
    cmd_t c;
    c = CMD_OTHER;
    if (cs_n_i) begin
      c = CMD_NOP;
    end else if ({ras_n_i, cas_n_i, we_n_i} == 3'h7) begin
      c = CMD_NOP;
    end else if ({ras_n_i, cas_n_i, we_n_i} == 3'h0) begin
      c = (ba_i == 3'h0) ? CMD_MODE : CMD_OTHER;
    end else if ({ras_n_i, cas_n_i, we_n_i} == 3'h5) begin
      c = CMD_READ;
    end else if ({ras_n_i, cas_n_i, we_n_i} == 3'h4) begin
      c = CMD_WRITE;
    end else if ({ras_n_i, cas_n_i, we_n_i} == 3'h6) begin
      c = CMD_TERM;
    end
    return c;
  endfunction

  assign cmd = decode_cmd(cs_n, ras_n, cas_n, we_n, ba);
  assign last_beat = st_q.bl8 ? LAST_BEAT_8 : LAST_BEAT_4;
  assign cl_code = addr[CL_LSB +: 3];
  assign wr_code = addr[WR_LSB +: 3];

  // column for the beat currently held in the sequencer
  burst_order_gen u_order (
    .start(st_q.start),
    .beat(st_q.beat),
    .bl8(st_q.bl8),
    .interleave(st_q.interleave),
    .col(ord_col)
  );

  // ==========================================================================
  // next state: mode word load and burst sequencing
  always_comb begin
    st_d = st_q;
    st_d.dll_rst = 1'b0;
    st_d.col_valid = (st_q.state == ST_BURST);
    st_d.col = ord_col;
    if (cmd == CMD_MODE) begin
      st_d.mode_loaded = 1'b1;
      // four or eight
      // a reserved code keeps the previous length, so bursts stay sized
      if (addr[BL_LSB +: 3] == BL_CODE_8) begin
        st_d.bl8 = 1'b1;
        st_d.bl_rsvd = 1'b0;
      end else if (addr[BL_LSB +: 3] == BL_CODE_4) begin
        st_d.bl8 = 1'b0;
        st_d.bl_rsvd = 1'b0;
      end else begin
        st_d.bl_rsvd = 1'b1;
      end
      st_d.interleave = addr[BT_BIT];
      st_d.cl_rsvd = (cl_code == CL_CODE_RSVD);
      if (cl_code == CL_CODE_9) begin
        st_d.cl = CL_CYC_9;
      end else if (cl_code == CL_CODE_8) begin
        st_d.cl = CL_CYC_8;
      end else begin
        st_d.cl = {1'b0, cl_code};
      end
      st_d.wr = (wr_code == 3'h0) ? WR_CODE0_CYC : 4'({1'b0, wr_code} + WR_CODE_OFFSET);
      st_d.dal = 5'({1'b0, st_d.wr} + {1'b0, PRECHARGE_CYCLES});
      st_d.tm = addr[TM_BIT];
      st_d.dll_rst = addr[DLL_BIT];
      st_d.pd_slow = addr[PD_BIT];
      // bit thirteen
      // on the word-wide part the pin does not exist and is ignored
      st_d.a13_err = BYTE_WIDE && addr[A13_BIT];
      st_d.intr_err = 1'b0;
      st_d.term_seen = 1'b0;
    end
    if (cmd == CMD_TERM) begin
      st_d.term_seen = 1'b1;
    end
    case (st_q.state)
      ST_IDLE: begin
        if (cmd == CMD_READ || cmd == CMD_WRITE) begin
          st_d.state = ST_BURST;
          st_d.is_write = (cmd == CMD_WRITE);
          st_d.start = addr[2:0];
          st_d.beat = 3'h0;
        end
      end
      ST_BURST: begin
        if (st_q.beat == last_beat) begin
          if (cmd == CMD_READ || cmd == CMD_WRITE) begin
            st_d.is_write = (cmd == CMD_WRITE);
            st_d.start = addr[2:0];
            st_d.beat = 3'h0;
          end else begin
            st_d.state = ST_IDLE;
          end
        end else begin
          st_d.beat = 3'(st_q.beat + 3'h1);
          if (st_q.bl8 && ((cmd == CMD_READ && !st_q.is_write) ||
                           (cmd == CMD_WRITE && st_q.is_write))) begin
            st_d.start = addr[2:0];
            st_d.beat = 3'h0;
          end else if (cmd == CMD_READ || cmd == CMD_WRITE || cmd == CMD_MODE) begin
            // short burst and opposite-type interrupt protected
            // an intruding read or write is dropped and the burst runs on; a mode word still loads
            st_d.intr_err = 1'b1;
          end
        end
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // state register; mode fields have no defined value, zero chosen
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register
  assign mode_loaded = st_q.mode_loaded;
  assign burst_len8 = st_q.bl8;
  assign burst_order_select = st_q.interleave;
  assign cas_latency = st_q.cl;
  assign write_recovery = st_q.wr;
  assign autopre_delay = st_q.dal;
  assign powerdown_exit_speed = st_q.pd_slow;
  assign test_select_bit = st_q.tm;
  assign dll_reset_pulse = st_q.dll_rst;
  assign bl_code_reserved = st_q.bl_rsvd;
  assign cl_code_reserved = st_q.cl_rsvd;
  assign a13_error = st_q.a13_err;
  assign burst_active = (st_q.state == ST_BURST);
  assign burst_is_write = st_q.is_write;
  assign col_valid = st_q.col_valid;
  assign col_index = st_q.col;
  assign interrupt_error = st_q.intr_err;
  assign terminate_seen = st_q.term_seen;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_bl_decode;
    (cmd == CMD_MODE && addr[2:0] == BL_CODE_8) |=> burst_len8 && !bl_code_reserved;
  endproperty
  a_bl_decode: assert property (p_bl_decode) else $error("length eight not decoded");

  property p_order_sel;
    (cmd == CMD_MODE) |=> burst_order_select == $past(addr[3]);
  endproperty
  a_order_sel: assert property (p_order_sel) else $error("order bit not loaded");

  property p_cl_nine;
    (cmd == CMD_MODE && addr[6:4] == 3'h0) |=> cas_latency == 4'h9;
  endproperty
  a_cl_nine: assert property (p_cl_nine) else $error("latency code zero not nine");

  property p_wr_decode;
    (cmd == CMD_MODE && addr[11:9] == 3'h7) |=> write_recovery == 4'h8;
  endproperty
  a_wr_decode: assert property (p_wr_decode) else $error("recovery code seven not eight");

  property p_dal_sum;
    mode_loaded |-> autopre_delay == 5'(write_recovery + PRECHARGE_CYCLES);
  endproperty
  a_dal_sum: assert property (p_dal_sum) else $error("precharge delay wrong");

  property p_dll;
    (cmd == CMD_MODE && addr[8]) |=> dll_reset_pulse ##1
      (!dll_reset_pulse || $past(cmd == CMD_MODE && addr[8]));
  endproperty
  a_dll: assert property (p_dll) else $error("dll reset pulse wrong");

  property p_first_col;
    (!burst_active && (cmd == CMD_READ || cmd == CMD_WRITE)) |-> ##2 col_valid && col_index == $past(addr[2:0], 2);
  endproperty
  a_first_col: assert property (p_first_col) else $error("first column not start");

  property p_interleave;
    (burst_active && burst_order_select && burst_len8 && st_q.start == 3'h3 && st_q.beat == 3'h4) |=> col_index == 3'h7;
  endproperty
  a_interleave: assert property (p_interleave) else $error("interleave order wrong");

  property p_seq_half;
    (burst_active && !burst_order_select && burst_len8 && st_q.start == 3'h1 && st_q.beat == 3'h3) |=> col_index == 3'h0;
  endproperty
  a_seq_half: assert property (p_seq_half) else $error("sequential wrap wrong");

  property p_bl4_end;
    (burst_active && !burst_len8 && st_q.beat == 3'h3 && cmd != CMD_READ && cmd != CMD_WRITE) |=> !burst_active;
  endproperty
  a_bl4_end: assert property (p_bl4_end) else $error("short burst length wrong");

  property p_no_gap;
    (burst_active && st_q.beat == last_beat && cmd == CMD_READ) |=> burst_active && st_q.beat == 3'h0;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("chained burst has gap");

  property p_bad_intr;
    (burst_active && st_q.beat != last_beat && (cmd == CMD_READ || cmd == CMD_WRITE) &&
     (!burst_len8 || burst_is_write != (cmd == CMD_WRITE))) |=> interrupt_error;
  endproperty
  a_bad_intr: assert property (p_bad_intr) else $error("forbidden interrupt not flagged");

  c_seq8: cover property (burst_active && burst_len8 && !burst_order_select && st_q.beat == 3'h7);
  c_chain: cover property (burst_active && st_q.beat == last_beat && cmd == CMD_WRITE);
  c_intr8: cover property (burst_active && burst_len8 && st_q.beat == 3'h2 && cmd == CMD_READ);

endmodule

`default_nettype wire

/* shared/mode_word_pkg.sv */
/*
  Shared constants for the primary mode word decoder and the burst
  sequencer: field positions, code points, decoded values and command codes.
  Assumes a single memory clock domain; no reset value exists for the word.
*/
package mode_word_pkg;

  // ==========================================================================
  // field positions inside the mode word
  localparam int MODE_WIDTH = 14;
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int TM_BIT = 7;
  localparam int DLL_BIT = 8;
  localparam int WR_LSB = 9;
  localparam int PD_BIT = 12;
  localparam int A13_BIT = 13;

  // ==========================================================================
  // burst length codes and beat counts
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] LAST_BEAT_4 = 3'h3;
  localparam logic [2:0] LAST_BEAT_8 = 3'h7;

  // ==========================================================================
  // cas latency: codes 3..7 map to themselves, 1 to 8, 0 to 9, 2 reserved
  localparam logic [2:0] CL_CODE_RSVD = 3'h2;
  localparam logic [2:0] CL_CODE_8 = 3'h1;
  localparam logic [2:0] CL_CODE_9 = 3'h0;
  localparam logic [3:0] CL_CYC_8 = 4'h8;
  localparam logic [3:0] CL_CYC_9 = 4'h9;

  // ==========================================================================
  // write recovery: code n gives n+1 cycles, code 0 gives 9
  localparam logic [3:0] WR_CODE0_CYC = 4'h9;
  localparam logic [3:0] WR_CODE_OFFSET = 4'h1;

  // ==========================================================================
  // decoded commands from the control pins
  typedef enum logic [2:0] {
    CMD_NOP,
    CMD_MODE,
    CMD_READ,
    CMD_WRITE,
    CMD_TERM,
    CMD_OTHER
  } cmd_t;

  typedef enum logic {
    ST_IDLE,
    ST_BURST
  } burst_state_t;

endpackage

/* core/burst_order_gen.sv */
/*
  Column order generator for one beat of a burst.
  Assumes start and beat are stable registered values; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module burst_order_gen (
  input wire logic [2:0] start,
  input wire logic [2:0] beat,
  input wire logic bl8,
  input wire logic interleave,
  output logic [2:0] col
);

  logic [2:0] cnt;
  logic [2:0] seq_col;

  // ==========================================================================
  // order arithmetic
  // a short burst never flips the half, so the counter top bit is masked
  assign cnt = {bl8 & beat[2], beat[1:0]};

  // nibble wrap
  // sequential wraps modulo four inside a half, then walks the other half
  assign seq_col = {start[2] ^ cnt[2], 2'(start[1:0] + cnt[1:0])};

  assign col = interleave ? (start ^ cnt) : seq_col;

endmodule

`default_nettype wire

/* test/mem_ctrl_model.sv */
/*
  Behavioural memory controller that turns bench requests into command pins.
  Assumes the bench changes req, kind and word just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module mem_ctrl_model
  import mode_word_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire cmd_t kind,
  input wire logic [13:0] word,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] ba,
  output logic [13:0] addr
);
  // ==========================================================================
  // last driven address, so released pins never echo it
  logic [13:0] last_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_q <= 14'h0;
    end else if (req) begin
      last_q <= word;
    end
  end

  // ==========================================================================
  // pin encoding; idle shows the inverted last address
  // intrusions only on bench request
  // words come from the bench builder
  always_comb begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 3'h7;
    addr = ~last_q;
    if (req) begin
      addr = word;
      case (kind)
        CMD_MODE: begin
          {cs_n, ras_n, cas_n, we_n} = 4'h0;
          ba = 3'h0;
        end
        CMD_READ: {cs_n, ras_n, cas_n, we_n} = 4'h5;
        CMD_WRITE: {cs_n, ras_n, cas_n, we_n} = 4'h4;
        CMD_TERM: {cs_n, ras_n, cas_n, we_n} = 4'h6;
        default: {cs_n, ras_n, cas_n, we_n} = 4'hf;
      endcase
    end
  end
endmodule

`default_nettype wire

/* test/sdram_mode_word_and_burst_order_test.sv */
/*
  Self-checking bench for the mode word decoder and burst sequencer.
  Assumes the partner model drives all command pins from bench requests.
*/
`timescale 1ns/1ps
`default_nettype none

module sdram_mode_word_and_burst_order_test;
  import mode_word_pkg::*;
  localparam logic [3:0] PRE = 4'h3;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic req = 1'b0;
  cmd_t kind = CMD_NOP;
  logic [13:0] word = 14'h0;
  wire logic cs_n, ras_n, cas_n, we_n, loaded, len8, order, pd, tsel, dll, blr, clr, a13e;
  wire logic act, isw, cv, intr, term;
  wire logic [2:0] ba, col;
  wire logic [13:0] addr;
  wire logic [3:0] cl, wr;
  wire logic [4:0] apd;
  int err_total = 0;
  int check_count = 0;
  int cyc = 0;
  int tck_ps[3] = '{2500, 1875, 1700};
  logic [2:0] colq[$];
  int tq[$];

  // ==========================================================================
  // clock, partner and device
  always #5 clk = ~clk;
  mem_ctrl_model i_ctrl (.clk(clk), .rst(rst), .req(req), .kind(kind), .word(word),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));
  mode_word_ctrl #(.BYTE_WIDE(1'b1), .PRECHARGE_CYCLES(PRE)) i_dut (.clk(clk), .rst(rst),
    .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr),
    .mode_loaded(loaded), .burst_len8(len8), .burst_order_select(order),
    .cas_latency(cl), .write_recovery(wr), .autopre_delay(apd),
    .powerdown_exit_speed(pd), .test_select_bit(tsel), .dll_reset_pulse(dll),
    .bl_code_reserved(blr), .cl_code_reserved(clr), .a13_error(a13e),
    .burst_active(act), .burst_is_write(isw), .col_valid(cv), .col_index(col),
    .interrupt_error(intr), .terminate_seen(term));

  // ==========================================================================
  // beat monitor: column and cycle of each valid beat
  always @(posedge clk) begin
    cyc++;
    if (cv === 1'b1) begin
      colq.push_back(col);
      tq.push_back(cyc);
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(input cmd_t k, input logic [13:0] w);
    @(posedge clk);
    req <= 1'b1;
    kind <= k;
    word <= w;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      req <= 1'b0;
    end
    #1;
  endtask
  // mode word builder keeps test bit and bit thirteen low
  // test bit low
  function automatic logic [13:0] mw(input logic [2:0] w, c, b, input logic il, p, d);
    return {1'b0, p, w, d, 1'b0, c, il, b};
  endfunction
  task automatic setm(input logic [2:0] b, input logic il);
    issue(CMD_MODE, mw(3'h1, 3'h3, b, il, 1'b0, 1'b0));
    idle(2);
  endtask
  task automatic cols(input logic [2:0] s, input logic b8, il, input int off);
    logic [2:0] c;
    for (int i = 0; i < (b8 ? 8 : 4); i++) begin
      c = b8 ? 3'(i) : {1'b0, 2'(i)};
      chk(8'(colq[off+i]), 8'(il ? s ^ c : {s[2] ^ c[2], s[1:0] + c[1:0]}));
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // watchdog, far beyond the roughly 480 cycles the tests take
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  // ==========================================================================
  // test sequence
  initial begin
    int n;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    chk(8'(loaded), 8'h0);
    chk(8'(len8), 8'h0);
    for (int i = 0; i < 8; i++) begin
      issue(CMD_MODE, mw(3'(i), 3'h3, BL_CODE_8, 1'b0, 1'b0, 1'b0));
      idle(2);
      chk(8'(wr), 8'(i == 0 ? 9 : i + 1));
      chk(8'(apd), 8'((i == 0 ? 9 : i + 1) + PRE));
    end
    chk(8'(loaded), 8'h1);
    for (int i = 0; i < 8; i++) begin
      issue(CMD_MODE, mw(3'h1, 3'(i), BL_CODE_4, 1'b0, 1'b0, 1'b0));
      idle(2);
      chk(8'(cl), 8'(i == 0 ? 9 : (i == 1 ? 8 : i)));
      chk(8'(clr), 8'(i == 2));
    end
    // the dll pulse stands one cycle only, so look right after the load
    issue(CMD_MODE, mw(3'h1, 3'h3, BL_CODE_8, 1'b1, 1'b1, 1'b1) | 14'h2000);
    idle(1);
    chk(8'(dll), 8'h1);
    chk(8'(pd), 8'h1);
    chk(8'(a13e), 8'h1);
    chk(8'(order), 8'h1);
    chk(8'(tsel), 8'h0);
    idle(1);
    chk(8'(dll), 8'h0);
    // reserved length code must leave length eight in place
    issue(CMD_MODE, mw(3'h1, 3'h3, 3'h5, 1'b0, 1'b0, 1'b0));
    idle(2);
    chk(8'(len8), 8'h1);
    chk(8'(blr), 8'h1);
    chk(8'(a13e), 8'h0);
    chk(8'(pd), 8'h0);
    chk(8'(order), 8'h0);
    // recovery cycles rounded up from picoseconds: 15/2.5, 15/1.875, 15/1.7
    foreach (tck_ps[k]) begin
      n = (15000 + tck_ps[k] - 1) / tck_ps[k];
      issue(CMD_MODE, mw(3'(n == 9 ? 0 : n - 1), 3'h3, BL_CODE_4, 1'b0, 1'b0, 1'b0));
      idle(2);
      chk(8'(wr), 8'(n));
    end
    // every start position, both orders, both lengths, reads sequential and writes interleaved
    for (int il = 0; il < 2; il++) begin
      for (int b = 0; b < 2; b++) begin
        setm(b ? BL_CODE_8 : BL_CODE_4, il[0]);
        for (int s = 0; s < (b ? 8 : 4); s++) begin
          colq.delete();
          issue(il ? CMD_WRITE : CMD_READ, 14'(s));
          idle(12);
          chk(8'(colq.size()), 8'(b ? 8 : 4));
          cols(3'(s), b[0], il[0], 0);
          // table value: interleaved start three gives seven at beat four
          if (il == 1 && b == 1 && s == 3) begin
            chk(8'(colq[4]), 8'h7);
          end
        end
      end
    end
    // seamless writes chained on the last beat, eight cycles after taking
    setm(BL_CODE_8, 1'b0);
    colq.delete();
    tq.delete();
    issue(CMD_WRITE, 14'h1);
    idle(7);
    issue(CMD_WRITE, 14'h6);
    idle(2);
    chk(8'(isw), 8'h1);
    idle(12);
    chk(8'(colq.size()), 8'd16);
    chk(8'(tq[15] - tq[0]), 8'd15);
    cols(3'h1, 1'b1, 1'b0, 0);
    cols(3'h6, 1'b1, 1'b0, 8);
    chk(8'(colq[3]), 8'h0);
    chk(8'(colq[7]), 8'h4);
    chk(8'(colq[10]), 8'h4);
    // length eight: read on read allowed, write on read refused
    issue(CMD_READ, 14'h0);
    idle(2);
    issue(CMD_READ, 14'h4);
    idle(12);
    chk(8'(intr), 8'h0);
    issue(CMD_READ, 14'h0);
    idle(2);
    issue(CMD_WRITE, 14'h0);
    idle(2);
    chk(8'(intr), 8'h1);
    idle(10);
    setm(BL_CODE_4, 1'b0);
    chk(8'(intr), 8'h0);
    // terminate encoding is flagged but leaves the burst whole
    colq.delete();
    issue(CMD_READ, 14'h2);
    idle(1);
    issue(CMD_TERM, 14'h0);
    idle(10);
    chk(8'(term), 8'h1);
    chk(8'(colq.size()), 8'h4);
    chk(8'(intr), 8'h0);
    chk(8'(act), 8'h0);
    // length four refuses any interruption
    colq.delete();
    issue(CMD_READ, 14'h0);
    idle(1);
    issue(CMD_READ, 14'h1);
    idle(2);
    chk(8'(intr), 8'h1);
    chk(8'(act), 8'h1);
    idle(8);
    chk(8'(colq.size()), 8'h4);
    end_of_test();
  end
endmodule

`default_nettype wire
